// *** verilog/exec_pkg.sv ***
// shared constants, register map and carrier types for the return / rotate executor
package exec_pkg;
  localparam int PC_W        = 21;
  localparam int STACK_DEPTH = 31;
  localparam int PTR_W       = 5;
  localparam int FADDR_W     = 12;
  localparam int PADDR_W     = 8;

  // register byte offsets
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_WREG   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BANK   = 8'h0c;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_PCLAT  = 8'h14;
  localparam logic [7:0] OFF_SHADOW = 8'h18;
  localparam logic [7:0] OFF_STACK  = 8'h1c;
  localparam logic [7:0] OFF_CFG    = 8'h20;
  localparam logic [7:0] OFF_INDEX  = 8'h24;
  localparam logic [7:0] OFF_FADDR  = 8'h28;
  localparam logic [7:0] OFF_FDATA  = 8'h2c;

  // field positions
  localparam int ST_C            = 0;
  localparam int ST_Z            = 2;
  localparam int ST_N            = 4;
  localparam int PCLAT_UP_LSB    = 8;
  localparam int SH_ST_LSB       = 8;
  localparam int SH_BANK_LSB     = 16;
  localparam int STACK_DEPTH_LSB = 24;
  localparam int OP_S_BIT        = 0;
  localparam int OP_A_BIT        = 8;
  localparam int OP_D_BIT        = 9;

  // reset values
  localparam logic [7:0]         WREG_RST   = 8'h00;
  localparam logic [4:0]         STATUS_RST = 5'h00;
  localparam logic [3:0]         BANK_RST   = 4'h0;
  localparam logic [PC_W-1:0]    PC_RST     = 21'h000000;
  localparam logic [FADDR_W-1:0] INDEX_RST  = 12'h000;
  localparam logic               EXT_RST    = 1'b0;

  // opcode fields and addressing
  localparam logic [14:0] RET_OP_TOP      = 15'h0009;
  localparam logic [5:0]  ROT_OP_TOP      = 6'h0d;
  localparam logic [7:0]  INDEXED_MAX     = 8'h5f;
  localparam logic [3:0]  ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0]  SFR_BANK        = 4'hf;

  // timing, in instruction cycles of Q_PER_CYCLE pclk quarters
  localparam int Q_PER_CYCLE = 4;
  localparam int RET_CYCLES  = 2;
  localparam int ROT_CYCLES  = 1;

  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} exec_state_t;

  typedef struct packed {
    logic            push;
    logic            pop;
    logic [PC_W-1:0] data;
  } stack_cmd_t;

  typedef struct packed {
    logic               en;
    logic [FADDR_W-1:0] addr;
    logic [7:0]         data;
  } file_wr_t;
endpackage : exec_pkg

// *** verilog/return_stack.sv ***
// hardware return stack holding program-counter values
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = exec_pkg::STACK_DEPTH
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           clk_en,
  input  wire exec_pkg::stack_cmd_t           cmd,
  output logic     [exec_pkg::PC_W-1:0]       stack_top_entry,
  output logic     [exec_pkg::PTR_W-1:0]      depth
);
  logic [exec_pkg::PC_W-1:0]  mem [DEPTH];
  logic [exec_pkg::PTR_W-1:0] ptr_ff;

  // overflow drops the push, underflow leaves the pointer at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_ff <= '0;
    end else if (clk_en) begin
      if (cmd.push && ptr_ff < exec_pkg::PTR_W'(DEPTH)) begin
        mem[ptr_ff] <= cmd.data;
        ptr_ff      <= ptr_ff + 1'b1;
      end else if (cmd.pop && ptr_ff != '0) begin
        ptr_ff <= ptr_ff - 1'b1;
      end
    end
  end

  // an empty stack reads as zero
  assign stack_top_entry = (ptr_ff == '0) ? '0 : mem[ptr_ff - 1'b1];
  assign depth           = ptr_ff;
endmodule : return_stack

// *** verilog/byte_file.sv ***
// data memory: general purpose file with asynchronous read
`timescale 1ns/1ps
module byte_file #(
  parameter int ADDR_W = exec_pkg::FADDR_W
) (
  input  wire logic                  pclk,
  input  wire logic                  clk_en,
  input  wire exec_pkg::file_wr_t    wr,
  input  wire logic     [ADDR_W-1:0] rd_addr,
  output logic          [7:0]        rd_data
);
  logic [7:0] general_purpose_file [2**ADDR_W];

  always_ff @(posedge pclk) begin
    if (clk_en && wr.en) begin
      general_purpose_file[wr.addr] <= wr.data;
    end
  end

  assign rd_data = general_purpose_file[rd_addr];
endmodule : byte_file

// *** verilog/return_rotate_exec.sv ***
// executor for subroutine return and rotate-left-through-carry, behind an apb slave
// Contract
// - return pops stack top into program counter
// - fast-restore set copies three shadows back
// - fast-restore clear leaves working, flags, bank
// - return never touches program counter latches
// - rotate left; bit7 to carry, carry in
// - destination bit picks working or file
// - access bit clear uses access bank
// - access bit set uses bank selector
// - extended mode indexes file addresses up to 95
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module return_rotate_exec (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           clk_en,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [exec_pkg::PADDR_W-1:0]   paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr
);
  typedef struct packed {
    exec_pkg::exec_state_t            st;
    logic [15:0]                      opcode;
    logic [1:0]                       q;
    logic                             cyc;
    logic [2:0]                       ticks;
    logic [7:0]                       wreg;
    logic [4:0]                       status;
    logic [3:0]                       bank_selector_reg;
    logic [exec_pkg::PC_W-1:0]        pc;
    logic [4:0]                       pc_upper_latch;
    logic [7:0]                       pc_high_latch;
    logic [7:0]                       work_shadow_reg;
    logic [4:0]                       flags_shadow_reg;
    logic [3:0]                       bank_shadow_reg;
    logic                             ext_en;
    logic [exec_pkg::FADDR_W-1:0]     index_base;
    logic [exec_pkg::FADDR_W-1:0]     faddr;
    logic [7:0]                       operand;
    logic [7:0]                       result;
    logic                             pready;
    logic                             pslverr;
    logic [31:0]                      prdata;
  } core_t;

  localparam logic [1:0] LAST_Q    = 2'(exec_pkg::Q_PER_CYCLE - 1);
  localparam int         RET_TICKS = exec_pkg::Q_PER_CYCLE * exec_pkg::RET_CYCLES - 1;
  localparam int         ROT_TICKS = exec_pkg::Q_PER_CYCLE * exec_pkg::ROT_CYCLES - 1;

  core_t                          r_ff;
  core_t                          nxt_r;
  exec_pkg::stack_cmd_t           stk_cmd;
  exec_pkg::file_wr_t             file_wr;
  logic [exec_pkg::PC_W-1:0]      stack_top_entry;
  logic [exec_pkg::PTR_W-1:0]     stk_depth;
  logic [exec_pkg::FADDR_W-1:0]   eff_addr;
  logic [exec_pkg::FADDR_W-1:0]   rd_addr;
  logic [7:0]                     rd_data;
  logic [7:0]                     fld;
  logic                           ret_hit;
  logic                           rot_hit;
  logic                           last_q;
  logic                           access;
  logic                           done;

  return_stack #(.DEPTH(exec_pkg::STACK_DEPTH)) u_stack (
    .pclk            (pclk),
    .presetn         (presetn),
    .clk_en          (clk_en),
    .cmd             (stk_cmd),
    .stack_top_entry (stack_top_entry),
    .depth           (stk_depth)
  );

  byte_file #(.ADDR_W(exec_pkg::FADDR_W)) u_file (
    .pclk    (pclk),
    .clk_en  (clk_en),
    .wr      (file_wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  assign fld     = r_ff.opcode[7:0];
  assign ret_hit = r_ff.opcode[15:1] == exec_pkg::RET_OP_TOP;
  assign rot_hit = r_ff.opcode[15:10] == exec_pkg::ROT_OP_TOP;
  assign last_q  = r_ff.q == LAST_Q;
  assign access  = psel && penable;
  assign done    = r_ff.st == exec_pkg::ST_EXEC && last_q && (rot_hit || r_ff.cyc);

  // operand address resolution for the rotate
  always_comb begin
    if (r_ff.opcode[exec_pkg::OP_A_BIT]) begin
      eff_addr = {r_ff.bank_selector_reg, fld};
    end else if (r_ff.ext_en && fld <= exec_pkg::INDEXED_MAX) begin
      eff_addr = r_ff.index_base + exec_pkg::FADDR_W'(fld);
    end else if (fld <= exec_pkg::INDEXED_MAX) begin
      eff_addr = {exec_pkg::ACCESS_LOW_BANK, fld};
    end else begin
      eff_addr = {exec_pkg::SFR_BANK, fld};
    end
  end

  assign rd_addr = (r_ff.st == exec_pkg::ST_EXEC) ? eff_addr : r_ff.faddr;

  always_comb begin
    nxt_r   = r_ff;
    stk_cmd = '0;
    file_wr = '0;
    // answer stands one cycle; the master samples it at that edge
    if (r_ff.pready) begin
      nxt_r.pready  = 1'b0;
      nxt_r.pslverr = 1'b0;
      if (access && pwrite && !r_ff.pslverr) begin
        if (paddr == exec_pkg::OFF_WREG) begin
          nxt_r.wreg = pwdata[7:0];
        end else if (paddr == exec_pkg::OFF_STATUS) begin
          nxt_r.status = pwdata[4:0];
        end else if (paddr == exec_pkg::OFF_BANK) begin
          nxt_r.bank_selector_reg = pwdata[3:0];
        end else if (paddr == exec_pkg::OFF_PC) begin
          nxt_r.pc = pwdata[exec_pkg::PC_W-1:0];
        end else if (paddr == exec_pkg::OFF_PCLAT) begin
          nxt_r.pc_high_latch  = pwdata[7:0];
          nxt_r.pc_upper_latch = pwdata[exec_pkg::PCLAT_UP_LSB +: 5];
        end else if (paddr == exec_pkg::OFF_SHADOW) begin
          nxt_r.work_shadow_reg  = pwdata[7:0];
          nxt_r.flags_shadow_reg = pwdata[exec_pkg::SH_ST_LSB +: 5];
          nxt_r.bank_shadow_reg  = pwdata[exec_pkg::SH_BANK_LSB +: 4];
        end else if (paddr == exec_pkg::OFF_STACK) begin
          stk_cmd.push = 1'b1;
          stk_cmd.data = pwdata[exec_pkg::PC_W-1:0];
        end else if (paddr == exec_pkg::OFF_CFG) begin
          nxt_r.ext_en = pwdata[0];
        end else if (paddr == exec_pkg::OFF_INDEX) begin
          nxt_r.index_base = pwdata[exec_pkg::FADDR_W-1:0];
        end else if (paddr == exec_pkg::OFF_FADDR) begin
          nxt_r.faddr = pwdata[exec_pkg::FADDR_W-1:0];
        end else if (paddr == exec_pkg::OFF_FDATA) begin
          file_wr.en   = 1'b1;
          file_wr.addr = r_ff.faddr;
          file_wr.data = pwdata[7:0];
        end
      end
    end
    case (r_ff.st)
      exec_pkg::ST_IDLE: begin
        if (access && !r_ff.pready) begin
          nxt_r.prdata = '0;
          nxt_r.pready = 1'b1;
          if (pwrite && paddr == exec_pkg::OFF_INSTR) begin
            // for a return or rotate opcode the answer is held back until the instruction retires
            nxt_r.opcode = pwdata[15:0];
            if (pwdata[15:1] == exec_pkg::RET_OP_TOP || pwdata[15:10] == exec_pkg::ROT_OP_TOP)
            begin
              nxt_r.st     = exec_pkg::ST_EXEC;
              nxt_r.pready = 1'b0;
              nxt_r.q      = '0;
              nxt_r.cyc    = 1'b0;
              nxt_r.ticks  = '0;
            end else begin
              nxt_r.pslverr = 1'b1;
            end
          end else if (paddr == exec_pkg::OFF_INSTR) begin
            nxt_r.prdata = {16'h0000, r_ff.opcode};
          end else if (paddr == exec_pkg::OFF_WREG) begin
            nxt_r.prdata = {24'h000000, r_ff.wreg};
          end else if (paddr == exec_pkg::OFF_STATUS) begin
            nxt_r.prdata = {27'h0000000, r_ff.status};
          end else if (paddr == exec_pkg::OFF_BANK) begin
            nxt_r.prdata = {28'h0000000, r_ff.bank_selector_reg};
          end else if (paddr == exec_pkg::OFF_PC) begin
            nxt_r.prdata = {11'h000, r_ff.pc};
          end else if (paddr == exec_pkg::OFF_PCLAT) begin
            nxt_r.prdata = {19'h00000, r_ff.pc_upper_latch, r_ff.pc_high_latch};
          end else if (paddr == exec_pkg::OFF_SHADOW) begin
            nxt_r.prdata = {12'h000, r_ff.bank_shadow_reg, 3'h0, r_ff.flags_shadow_reg,
                            r_ff.work_shadow_reg};
          end else if (paddr == exec_pkg::OFF_STACK) begin
            nxt_r.prdata = {3'h0, stk_depth, 3'h0, stack_top_entry};
          end else if (paddr == exec_pkg::OFF_CFG) begin
            nxt_r.prdata = {31'h00000000, r_ff.ext_en};
          end else if (paddr == exec_pkg::OFF_INDEX) begin
            nxt_r.prdata = {20'h00000, r_ff.index_base};
          end else if (paddr == exec_pkg::OFF_FADDR) begin
            nxt_r.prdata = {20'h00000, r_ff.faddr};
          end else if (paddr == exec_pkg::OFF_FDATA) begin
            nxt_r.prdata = {24'h000000, rd_data};
          end else begin
            nxt_r.pslverr = 1'b1;
          end
        end
      end
      exec_pkg::ST_EXEC: begin
        nxt_r.q     = r_ff.q + 2'h1;
        nxt_r.ticks = r_ff.ticks + 3'h1;
        if (ret_hit) begin
          if (last_q && !r_ff.cyc) begin
            stk_cmd.pop = 1'b1;
            nxt_r.pc    = stack_top_entry;
            // with s clear nothing below runs, so working, flags and bank keep their values
            if (r_ff.opcode[exec_pkg::OP_S_BIT]) begin
              nxt_r.wreg              = r_ff.work_shadow_reg;
              nxt_r.status            = r_ff.flags_shadow_reg;
              nxt_r.bank_selector_reg = r_ff.bank_shadow_reg;
            end
            nxt_r.cyc = 1'b1;
          end
        end else begin
          if (r_ff.q == 2'h1) begin
            nxt_r.operand = rd_data;
          end
          if (r_ff.q == 2'h2) begin
            nxt_r.result = {r_ff.operand[6:0], r_ff.status[exec_pkg::ST_C]};
          end
          if (last_q) begin
            nxt_r.status[exec_pkg::ST_C] = r_ff.operand[7];
            nxt_r.status[exec_pkg::ST_N] = r_ff.result[7];
            nxt_r.status[exec_pkg::ST_Z] = r_ff.result == 8'h00;
            if (r_ff.opcode[exec_pkg::OP_D_BIT]) begin
              file_wr.en   = 1'b1;
              file_wr.addr = eff_addr;
              file_wr.data = r_ff.result;
            end else begin
              nxt_r.wreg = r_ff.result;
            end
          end
        end
        if (done) begin
          nxt_r.st     = exec_pkg::ST_IDLE;
          nxt_r.pready = 1'b1;
          nxt_r.prdata = '0;
        end
      end
      default: nxt_r.st = exec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_ff                   <= '0;
      r_ff.st                <= exec_pkg::ST_IDLE;
      r_ff.wreg              <= exec_pkg::WREG_RST;
      r_ff.status            <= exec_pkg::STATUS_RST;
      r_ff.bank_selector_reg <= exec_pkg::BANK_RST;
      r_ff.pc                <= exec_pkg::PC_RST;
      r_ff.ext_en            <= exec_pkg::EXT_RST;
      r_ff.index_base        <= exec_pkg::INDEX_RST;
    end else if (clk_en) begin
      r_ff <= nxt_r;
    end
  end

  assign prdata  = r_ff.prdata;
  assign pready  = r_ff.pready;
  assign pslverr = r_ff.pslverr;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pop_moment;
    clk_en && r_ff.st == exec_pkg::ST_EXEC && ret_hit && last_q && !r_ff.cyc;
  endsequence
  sequence s_rot_write;
    clk_en && r_ff.st == exec_pkg::ST_EXEC && rot_hit && last_q;
  endsequence

  property p_ret_pop_pc;
    s_pop_moment |=> r_ff.pc == $past(stack_top_entry);
  endproperty
  a_ret_pop_pc: assert property (p_ret_pop_pc) else $error("pc not loaded from stack top");

  property p_ret_restore;
    s_pop_moment ##0 r_ff.opcode[exec_pkg::OP_S_BIT] |=>
      r_ff.wreg == $past(r_ff.work_shadow_reg) && r_ff.status == $past(r_ff.flags_shadow_reg)
      && r_ff.bank_selector_reg == $past(r_ff.bank_shadow_reg);
  endproperty
  a_ret_restore: assert property (p_ret_restore) else $error("shadows not restored");

  property p_ret_keep;
    s_pop_moment ##0 !r_ff.opcode[exec_pkg::OP_S_BIT] |=>
      $stable(r_ff.wreg) && $stable(r_ff.status) && $stable(r_ff.bank_selector_reg);
  endproperty
  a_ret_keep: assert property (p_ret_keep) else $error("return without restore changed regs");

  property p_ret_latches;
    r_ff.st == exec_pkg::ST_EXEC && ret_hit |=>
      $stable(r_ff.pc_upper_latch) && $stable(r_ff.pc_high_latch);
  endproperty
  a_ret_latches: assert property (p_ret_latches) else $error("return changed pc latches");

  property p_ret_length;
    done && ret_hit |-> r_ff.ticks == 3'(RET_TICKS) && r_ff.cyc;
  endproperty
  a_ret_length: assert property (p_ret_length) else $error("return not two cycles");

  property p_rot_result;
    s_rot_write ##0 !r_ff.opcode[exec_pkg::OP_D_BIT] |=>
      r_ff.wreg == {$past(r_ff.operand[6:0]), $past(r_ff.status[exec_pkg::ST_C])}
      && r_ff.status[exec_pkg::ST_C] == $past(r_ff.operand[7]);
  endproperty
  a_rot_result: assert property (p_rot_result) else $error("rotate result wrong");

  property p_rot_dest;
    s_rot_write |-> file_wr.en == r_ff.opcode[exec_pkg::OP_D_BIT]
      && (!file_wr.en || file_wr.addr == eff_addr);
  endproperty
  a_rot_dest: assert property (p_rot_dest) else $error("rotate destination wrong");

  property p_addr_access;
    !r_ff.opcode[exec_pkg::OP_A_BIT] && !r_ff.ext_en |->
      eff_addr[7:0] == fld && eff_addr[11:8] == (fld > exec_pkg::INDEXED_MAX ?
      exec_pkg::SFR_BANK : exec_pkg::ACCESS_LOW_BANK);
  endproperty
  a_addr_access: assert property (p_addr_access) else $error("access bank address wrong");

  property p_addr_bank;
    r_ff.opcode[exec_pkg::OP_A_BIT] |-> eff_addr == {r_ff.bank_selector_reg, fld};
  endproperty
  a_addr_bank: assert property (p_addr_bank) else $error("banked address wrong");

  property p_addr_indexed;
    !r_ff.opcode[exec_pkg::OP_A_BIT] && r_ff.ext_en && fld <= exec_pkg::INDEXED_MAX |->
      eff_addr == r_ff.index_base + exec_pkg::FADDR_W'(fld);
  endproperty
  a_addr_indexed: assert property (p_addr_indexed) else $error("indexed address wrong");

  property p_rot_flags;
    s_rot_write |-> r_ff.ticks == 3'(ROT_TICKS) ##1
      r_ff.status[exec_pkg::ST_N] == $past(r_ff.result[7])
      && r_ff.status[exec_pkg::ST_Z] == ($past(r_ff.result) == 8'h00);
  endproperty
  a_rot_flags: assert property (p_rot_flags) else $error("rotate flags or length wrong");
endmodule : return_rotate_exec

// *** bench/return_and_rotate_carry_exec_tb.sv ***
// self-checking apb bench for the return and rotate-through-carry executor
`timescale 1ns/1ps
module return_and_rotate_carry_exec_tb;
  logic                          pclk = 1'b0;
  logic                          presetn;
  logic                          clk_en;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [exec_pkg::PADDR_W-1:0]  paddr;
  logic [31:0]                   pwdata;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  int                            miscompares = 0;
  int                            cmp_count = 0;
  int                            cycles = 0;
  int                            last_waits;
  logic                          last_err;
  logic [31:0]                   rv;

  return_rotate_exec return_rotate_exec_i (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  always #20 pclk = ~pclk;

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // a hung handshake would otherwise stall the run forever
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("unexpected at %0t: bench timeout", $time);
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  // entered just after a rising edge; waits are counted from the access phase
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel    <= 1'b1;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    last_waits = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      last_waits++;
      @(posedge pclk);
    end
    q = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    apb(1'b1, a, d, dummy);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0000_0000, q);
  endtask : rd

  // one rotate with its addressing set up; expectations from the rotation itself
  task automatic rot(input logic d, input logic a, input logic ext, input logic [3:0] bank,
                     input logic [11:0] idx, input logic [7:0] f, input logic [7:0] v,
                     input logic c, input logic [11:0] addr);
    logic [7:0]  res;
    logic [4:0]  st;
    logic [31:0] q;
    res = {v[6:0], c};
    st  = 5'h0a;
    st[exec_pkg::ST_C] = v[7];
    st[exec_pkg::ST_Z] = (res == 8'h00);
    st[exec_pkg::ST_N] = res[7];
    wr(exec_pkg::OFF_CFG, {31'h0, ext});
    wr(exec_pkg::OFF_BANK, {28'h0, bank});
    wr(exec_pkg::OFF_INDEX, {20'h0, idx});
    wr(exec_pkg::OFF_FADDR, {20'h0, addr});
    wr(exec_pkg::OFF_FDATA, {24'h0, v});
    wr(exec_pkg::OFF_WREG, 32'h0000_003c);
    wr(exec_pkg::OFF_STATUS, {27'h0, 4'h5, c});
    wr(exec_pkg::OFF_INSTR, {16'h0, exec_pkg::ROT_OP_TOP, d, a, f});
    chk(last_waits, 32'd5);
    rd(exec_pkg::OFF_STATUS, q);
    chk(q, {27'h0, st});
    rd(exec_pkg::OFF_FDATA, q);
    chk(q, {24'h0, d ? res : v});
    rd(exec_pkg::OFF_WREG, q);
    chk(q, {24'h0, d ? 8'h3c : res});
  endtask : rot

  initial begin
    presetn = 1'b0;
    clk_en  = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i <= 10; i++) begin
      rd(8'(i * 4), rv);
      chk(rv, 32'h0000_0000);
    end
    // unmapped and unaligned places answer with an error and zero
    rd(8'h30, rv);
    chk({31'h0, last_err}, 32'h1);
    chk(rv, 32'h0000_0000);
    rd(8'h05, rv);
    chk({31'h0, last_err}, 32'h1);

    wr(exec_pkg::OFF_STACK, 32'h0000_31a2);
    wr(exec_pkg::OFF_STACK, 32'h0001_4332);
    wr(exec_pkg::OFF_WREG, 32'h0000_0055);
    wr(exec_pkg::OFF_STATUS, 32'h0000_000a);
    wr(exec_pkg::OFF_BANK, 32'h0000_0003);
    wr(exec_pkg::OFF_PCLAT, 32'h0000_1fab);
    wr(exec_pkg::OFF_SHADOW, 32'h0009_1277);
    wr(exec_pkg::OFF_INSTR, {16'h0, exec_pkg::RET_OP_TOP, 1'b0});
    chk(last_waits, 32'd9);
    chk({31'h0, last_err}, 32'h0);
    rd(exec_pkg::OFF_PC, rv);
    chk(rv, 32'h0001_4332);
    rd(exec_pkg::OFF_STACK, rv);
    chk(rv, 32'h0100_31a2);
    rd(exec_pkg::OFF_WREG, rv);
    chk(rv, 32'h0000_0055);
    rd(exec_pkg::OFF_STATUS, rv);
    chk(rv, 32'h0000_000a);
    rd(exec_pkg::OFF_BANK, rv);
    chk(rv, 32'h0000_0003);
    rd(exec_pkg::OFF_PCLAT, rv);
    chk(rv, 32'h0000_1fab);

    // fast return with the clock enable dropped for three cycles mid-execution
    fork
      begin
        repeat (2) @(posedge pclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join_none
    wr(exec_pkg::OFF_INSTR, {16'h0, exec_pkg::RET_OP_TOP, 1'b1});
    chk(last_waits, 32'd12);
    rd(exec_pkg::OFF_PC, rv);
    chk(rv, 32'h0000_31a2);
    rd(exec_pkg::OFF_WREG, rv);
    chk(rv, 32'h0000_0077);
    rd(exec_pkg::OFF_STATUS, rv);
    chk(rv, 32'h0000_0012);
    rd(exec_pkg::OFF_BANK, rv);
    chk(rv, 32'h0000_0009);
    rd(exec_pkg::OFF_PCLAT, rv);
    chk(rv, 32'h0000_1fab);

    rot(1'b0, 1'b0, 1'b0, 4'h5, 12'h000, 8'h10, 8'he6, 1'b0, 12'h010);
    rot(1'b1, 1'b0, 1'b0, 4'h5, 12'h000, 8'h80, 8'h80, 1'b0, 12'hf80);
    rot(1'b1, 1'b1, 1'b0, 4'h9, 12'h000, 8'h20, 8'h55, 1'b1, 12'h920);
    rot(1'b1, 1'b0, 1'b1, 4'h9, 12'h300, 8'h5f, 8'h01, 1'b1, 12'h35f);
    rot(1'b1, 1'b0, 1'b1, 4'h9, 12'h300, 8'h60, 8'h7f, 1'b0, 12'hf60);
    rot(1'b0, 1'b1, 1'b1, 4'h2, 12'h300, 8'h10, 8'h81, 1'b1, 12'h210);

    // an opcode of neither kind is kept but refused and not executed
    wr(exec_pkg::OFF_INSTR, 32'h0000_1234);
    chk({31'h0, last_err}, 32'h1);
    rd(exec_pkg::OFF_INSTR, rv);
    chk(rv, 32'h0000_1234);
    rd(exec_pkg::OFF_PC, rv);
    chk(rv, 32'h0000_31a2);
    close_out();
  end
endmodule : return_and_rotate_carry_exec_tb
